//--- rtl/ocf_pkg.sv
// Package: shared constants, types and timing for the fault-response controller
`default_nettype none
package ocf_pkg;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int BLANK_TIME_MS = 21;
    localparam int RETRY_TIME_MS = 620;
    localparam int DEBOUNCE_TIME_MS = 16;
    localparam int NS_PER_MS = 1000000;
    localparam int BLANK_CYCLES = BLANK_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int RETRY_CYCLES = RETRY_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int CNT_W = 32;
    // Cycles before the sensed current follows a fresh turn-on through the synchroniser
    localparam int CONDUCT_SETTLE_CYCLES = 6;

    // ****************************************************************
    // Limit-type encoding, high select bit first
    // ****************************************************************
    typedef enum logic [1:0] {
        OCF_LATCH_OFF = 2'h0,
        OCF_AUTORETRY = 2'h1,
        OCF_CONTINUOUS = 2'h2
    } ocf_limit_t;

    localparam logic [1:0] SEL_LATCH = 2'h0;
    localparam logic [1:0] SEL_RETRY = 2'h1;

    // Gray-coded states along the usual path
    typedef enum logic [2:0] {
        ST_WAIT_DEB = 3'h0,
        ST_CONDUCT = 3'h1,
        ST_RETRY = 3'h3,
        ST_LATCHED = 3'h2,
        ST_THERMAL = 3'h6
    } ocf_state_t;

    // Comparator bundle from the analog front end
    typedef struct packed {
        logic ov_ext;
        logic ov_int;
        logic uv_ext;
        logic uv_int;
        logic overvoltage_lockout_above_sel;
        logic undervoltage_lockout_above_sel;
        logic overcurrent;
        logic reverse_current;
        logic over_temp;
        logic limit_pin_short;
        logic vdiff_low;
    } ocf_sense_t;

    localparam int SENSE_W = 11;
endpackage : ocf_pkg
`default_nettype wire

//--- rtl/ocf_sync.sv
// Three-stage synchroniser with agreement filter on the last two stages
`default_nettype none
module ocf_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit changes only once stages two and three agree
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_sync <= '0;
        else
        begin
            for (int i = 0; i < WIDTH; i++)
            begin
                if (s2_q[i] == s3_q[i])
                    o_sync[i] <= s3_q[i];
            end
        end
    end
endmodule // ocf_sync
`default_nettype wire

//--- rtl/ocf_timer.sv
// Restartable terminal-count timer
`default_nettype none
module ocf_timer #(
    parameter int CNT_W = 32
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_run,
    input wire logic [CNT_W-1:0] i_terminal,
    output logic o_done
);
    logic [CNT_W-1:0] cnt_q;

    // Counts while run is held; dropping run restarts from zero
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cnt_q <= '0;
        else if (!i_run)
            cnt_q <= '0;
        else if (cnt_q != i_terminal)
            cnt_q <= cnt_q + 1'b1;
    end

    assign o_done = i_run && (cnt_q == i_terminal);
endmodule // ocf_timer
`default_nettype wire

//--- rtl/ocf_ctrl.sv
// Fault-response controller: lockouts, limit type, blanking, retry, thermal
`default_nettype none
module ocf_ctrl
    import ocf_pkg::*;
#(
    parameter int BLANK_CNT = BLANK_CYCLES,
    parameter int RETRY_CNT = RETRY_CYCLES,
    parameter int DEBOUNCE_CNT = DEBOUNCE_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire ocf_pkg::ocf_sense_t i_sense,
    input wire logic i_type_sample_mode,
    input wire logic i_limit_type_sel_lo,
    input wire logic i_limit_type_sel_hi,
    input wire logic i_enable,
    input wire logic i_hv_enable_n,
    input wire logic i_reverse_block_disable,
    output logic o_fet_on,
    output logic o_current_limit_active,
    output logic o_reverse_block_on,
    output logic o_fault_flag_n_o,
    output logic o_fault_flag_n_oe,
    output ocf_pkg::ocf_limit_t o_limit_type
);
    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    localparam int PIN_W = SENSE_W + 6;
    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_s;
    ocf_sense_t sense;
    logic mode_s, sel_lo_s, sel_hi_s, en_s, hv_enable_n_n_s, rbd_s;

    assign pins_raw = {i_sense, i_type_sample_mode, i_limit_type_sel_lo,
                       i_limit_type_sel_hi, i_enable, i_hv_enable_n,
                       i_reverse_block_disable};

    ocf_sync #(.WIDTH(PIN_W)) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_async(pins_raw),
        .o_sync(pins_s)
    );

    assign {sense, mode_s, sel_lo_s, sel_hi_s, en_s, hv_enable_n_n_s, rbd_s} = pins_s;

    function automatic ocf_limit_t decode_type(input logic hi, input logic lo);
        case ({hi, lo})
            SEL_LATCH: decode_type = OCF_LATCH_OFF;
            SEL_RETRY: decode_type = OCF_AUTORETRY;
            default: decode_type = OCF_CONTINUOUS;
        endcase
    endfunction

    // ****************************************************************
    // Lockouts and enables
    // ****************************************************************
    logic ov_trip, uv_trip, switch_enabled, force_off;
    // select internal preset when pin sits below select level
    assign ov_trip = sense.overvoltage_lockout_above_sel ? sense.ov_ext : sense.ov_int;
    assign uv_trip = sense.undervoltage_lockout_above_sel ? sense.uv_ext : sense.uv_int;
    assign switch_enabled = !(hv_enable_n_n_s && !en_s);
    // Priority block over the overcurrent machine
    assign force_off = ov_trip || uv_trip || sense.limit_pin_short || !switch_enabled;

    // Enable in its off combination or input power lost clears a latched fault
    logic enable_reset;
    assign enable_reset = !switch_enabled || uv_trip;

    // ****************************************************************
    // Limit type selection
    // ****************************************************************
    ocf_limit_t limit_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            limit_q <= OCF_CONTINUOUS;
        else if (mode_s)
            limit_q <= decode_type(sel_hi_s, sel_lo_s);
        else if (sense.vdiff_low)
            limit_q <= decode_type(sel_hi_s, sel_lo_s);
    end

    // ****************************************************************
    // Timers
    // ****************************************************************
    ocf_state_t state_q;
    logic blank_run, blank_done, retry_run, retry_done, deb_run, deb_done;

    // Blanking only while overcurrent persists with the switch on
    assign blank_run = sense.overcurrent && (state_q == ST_CONDUCT) && !force_off;
    assign retry_run = (state_q == ST_RETRY);
    assign deb_run = (state_q == ST_WAIT_DEB) && !uv_trip;

    ocf_timer #(.CNT_W(CNT_W)) u_blank (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_run(blank_run),
        .i_terminal(CNT_W'(BLANK_CNT)),
        .o_done(blank_done)
    );
    ocf_timer #(.CNT_W(CNT_W)) u_retry (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_run(retry_run),
        .i_terminal(CNT_W'(RETRY_CNT)),
        .o_done(retry_done)
    );
    ocf_timer #(.CNT_W(CNT_W)) u_deb (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_run(deb_run),
        .i_terminal(CNT_W'(DEBOUNCE_CNT)),
        .o_done(deb_done)
    );

    // ****************************************************************
    // Fault-response state machine
    // ****************************************************************
    // Latched states persist through the force-off conditions; only the
    // enable or power cycle returns them to the debounce wait.
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state_q <= ST_WAIT_DEB;
        else
        begin
            case (state_q)
                ST_WAIT_DEB:
                begin
                    if (sense.over_temp)
                        state_q <= (limit_q == OCF_LATCH_OFF) ? ST_LATCHED : ST_THERMAL;
                    else if (deb_done && !force_off)
                        state_q <= ST_CONDUCT;
                end
                ST_CONDUCT:
                begin
                    if (force_off)
                        state_q <= ST_WAIT_DEB;
                    else if (sense.over_temp)
                        state_q <= (limit_q == OCF_LATCH_OFF) ? ST_LATCHED : ST_THERMAL;
                    else if (blank_done && limit_q == OCF_AUTORETRY)
                        state_q <= ST_RETRY;
                    else if (blank_done && limit_q == OCF_LATCH_OFF)
                        state_q <= ST_LATCHED;
                end
                ST_RETRY:
                begin
                    if (enable_reset)
                        state_q <= ST_WAIT_DEB;
                    else if (sense.over_temp)
                        state_q <= ST_THERMAL;
                    else if (retry_done)
                        state_q <= ST_CONDUCT;
                end
                ST_LATCHED:
                begin
                    if (enable_reset)
                        state_q <= ST_WAIT_DEB;
                end
                ST_THERMAL:
                begin
                    if (!sense.over_temp)
                    begin
                        if (limit_q == OCF_AUTORETRY)
                            state_q <= ST_RETRY;
                        else
                            state_q <= ST_WAIT_DEB;
                    end
                end
                default: state_q <= ST_WAIT_DEB;
            endcase
        end
    end

    // ****************************************************************
    // Fault flag
    // ****************************************************************
    // Sensed current lags a retry turn-on, so absence of overload counts only once settled
    logic [2:0] conduct_age_q;
    logic conduct_settled;
    assign conduct_settled = (state_q == ST_CONDUCT) && (conduct_age_q == 3'(CONDUCT_SETTLE_CYCLES));
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            conduct_age_q <= '0;
        else if (state_q != ST_CONDUCT)
            conduct_age_q <= '0;
        else if (!conduct_settled)
            conduct_age_q <= conduct_age_q + 3'h1;
    end
    logic oc_flag_q;
    // Blanking flag holds through retry cycles, drops when overload ends
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            oc_flag_q <= 1'b0;
        else if (blank_done)
            oc_flag_q <= 1'b1;
        else if (state_q == ST_LATCHED)
            oc_flag_q <= oc_flag_q;
        else if (conduct_settled && !sense.overcurrent)
            oc_flag_q <= 1'b0;
        else if (state_q == ST_WAIT_DEB)
            oc_flag_q <= 1'b0;
    end

    logic rev_trip, flag_any;
    assign rev_trip = sense.reverse_current && !rbd_s;
    assign flag_any = oc_flag_q || rev_trip || sense.over_temp || sense.limit_pin_short
                      || ov_trip || (state_q == ST_THERMAL);

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_fet_on <= 1'b0;
            o_current_limit_active <= 1'b0;
            o_reverse_block_on <= 1'b0;
            o_fault_flag_n_o <= 1'b0;
            o_fault_flag_n_oe <= 1'b1;
            o_limit_type <= OCF_CONTINUOUS;
        end
        else
        begin
            o_fet_on <= (state_q == ST_CONDUCT) && !force_off && !sense.over_temp;
            o_current_limit_active <= (state_q == ST_CONDUCT) && sense.overcurrent;
            o_reverse_block_on <= !rbd_s;
            o_fault_flag_n_o <= 1'b0;
            // Open drain: enable low pulls the flag low
            o_fault_flag_n_oe <= !flag_any;
            o_limit_type <= limit_q;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_oc_on;
        (state_q == ST_CONDUCT) && !force_off && sense.overcurrent;
    endsequence

    property p_lockout_off;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        force_off |=> !o_fet_on;
    endproperty
    a_lockout_off: assert property (p_lockout_off) else $error("FET on during lockout");

    property p_power_up_cont;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(i_rst_n) |-> limit_q == OCF_CONTINUOUS;
    endproperty
    a_power_up_cont: assert property (p_power_up_cont) else $error("Bad power-up type");

    property p_sample_cont;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        mode_s |=> limit_q == decode_type($past(sel_hi_s), $past(sel_lo_s));
    endproperty
    a_sample_cont: assert property (p_sample_cont) else $error("Type not sampled");

    property p_sample_hold;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (!mode_s && !sense.vdiff_low) |=> $stable(limit_q);
    endproperty
    a_sample_hold: assert property (p_sample_hold) else $error("Type changed");

    property p_retry_entry;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (blank_done && limit_q == OCF_AUTORETRY && state_q == ST_CONDUCT && !sense.over_temp)
        |=> state_q == ST_RETRY ##1 !o_fet_on;
    endproperty
    a_retry_entry: assert property (p_retry_entry) else $error("No retry");

    property p_latch;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (state_q == ST_LATCHED && !enable_reset) |=> state_q == ST_LATCHED;
    endproperty
    a_latch: assert property (p_latch) else $error("Latch released");

    property p_cont_flag;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (s_oc_on ##0 blank_done) |=> oc_flag_q ##1 !o_fault_flag_n_oe;
    endproperty
    a_cont_flag: assert property (p_cont_flag) else $error("Flag missing");

    property p_flag_causes;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (sense.limit_pin_short || ov_trip || sense.over_temp) |=> !o_fault_flag_n_oe;
    endproperty
    a_flag_causes: assert property (p_flag_causes) else $error("Flag not low");

    property p_thermal_now;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        sense.over_temp |=> !o_fet_on;
    endproperty
    a_thermal_now: assert property (p_thermal_now) else $error("Thermal late");

    property p_enable_table;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (hv_enable_n_n_s && !en_s) |=> !o_fet_on;
    endproperty
    a_enable_table: assert property (p_enable_table) else $error("Enable ignored");
endmodule // ocf_ctrl
`default_nettype wire

//--- verification/ocf_front_model.sv
// Behavioural model of the analog front end that feeds the fault controller
`default_nettype none
module ocf_front_model
    import ocf_pkg::*;
#(
    parameter int OV_PRESET_MV = 33000,
    parameter int UV_PRESET_MV = 19000
) (
    input wire logic [15:0] i_vin_mv,
    input wire logic [15:0] i_out_mv,
    input wire logic [15:0] i_ov_ext_mv,
    input wire logic [15:0] i_uv_ext_mv,
    input wire logic i_ov_pin_high,
    input wire logic i_uv_pin_high,
    input wire logic [15:0] i_load_ma,
    input wire logic [15:0] i_ilim_ma,
    input wire logic i_rev_flow,
    input wire logic [7:0] i_temp_c,
    input wire logic i_limit_set_pin_gnd,
    input wire logic i_fet_conducts,
    output var ocf_pkg::ocf_sense_t o_sense
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hot = 1'b0;
    logic limiting;
    // ****************************************************************
    // Sensing
    // ****************************************************************
    // Die sensor carries its own hysteresis band
    always @(i_temp_c)
    begin
        if (i_temp_c >= 8'd150)
            hot = 1'b1;
        else if (i_temp_c <= 8'd120)
            hot = 1'b0;
    end
    // Load current flows, and so trips, only while the pass FETs conduct
    assign limiting = i_fet_conducts && (i_load_ma > i_ilim_ma);
    always_comb
    begin
        o_sense.ov_ext = i_vin_mv > i_ov_ext_mv;
        o_sense.ov_int = 32'(i_vin_mv) > OV_PRESET_MV;
        o_sense.uv_ext = i_vin_mv < i_uv_ext_mv;
        o_sense.uv_int = 32'(i_vin_mv) < UV_PRESET_MV;
        o_sense.overvoltage_lockout_above_sel = i_ov_pin_high;
        o_sense.undervoltage_lockout_above_sel = i_uv_pin_high;
        o_sense.overcurrent = limiting;
        o_sense.reverse_current = i_rev_flow;
        o_sense.over_temp = hot;
        o_sense.limit_pin_short = i_limit_set_pin_gnd;
        // Conducting FET without limiting drops well under the window
        o_sense.vdiff_low = (i_fet_conducts && !limiting) ||
            ({1'b0, i_vin_mv} < {1'b0, i_out_mv} + 17'd600);
    end
endmodule // ocf_front_model
`default_nettype wire

//--- verification/tb_ocf_ctrl.sv
// Self-checking bench for the fault-response controller
`default_nettype none
module tb_ocf_ctrl;
    import ocf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BLK = 20;
    localparam int RTY = 50;
    localparam int DEB = 10;
    localparam int SLK = 12;
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    ocf_sense_t sense;
    logic mode = 1'b0;
    logic sel_lo = 1'b1;
    logic sel_hi = 1'b1;
    logic en = 1'b0;
    logic hv_n = 1'b1;
    logic rev_dis = 1'b0;
    logic [15:0] vin = 16'h5dc0;
    logic [15:0] vout = 16'h0;
    logic ov_sel = 1'b1;
    logic uv_sel = 1'b1;
    logic [15:0] load = 16'h64;
    logic rev = 1'b0;
    logic [7:0] temp = 8'h19;
    logic limit_set_pin_gnd = 1'b0;
    logic fet, cla, rbo, flag_o, flag_oe;
    ocf_limit_t ltype;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    // ****************************************************************
    // Clock, partner and design
    // ****************************************************************
    initial
    begin
        forever #5 clk = ~clk;
    end
    ocf_front_model ocf_front_model_i (.i_vin_mv(vin), .i_out_mv(vout),
        .i_ov_ext_mv(16'h9c40), .i_uv_ext_mv(16'h2710), .i_ov_pin_high(ov_sel),
        .i_uv_pin_high(uv_sel), .i_load_ma(load), .i_ilim_ma(16'h1f4), .i_rev_flow(rev),
        .i_temp_c(temp), .i_limit_set_pin_gnd(limit_set_pin_gnd), .i_fet_conducts(fet), .o_sense(sense));
    ocf_ctrl #(.BLANK_CNT(BLK), .RETRY_CNT(RTY), .DEBOUNCE_CNT(DEB)) ocf_ctrl_i (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_sense(sense), .i_type_sample_mode(mode),
        .i_limit_type_sel_lo(sel_lo), .i_limit_type_sel_hi(sel_hi), .i_enable(en),
        .i_hv_enable_n(hv_n), .i_reverse_block_disable(rev_dis), .o_fet_on(fet),
        .o_current_limit_active(cla), .o_reverse_block_on(rbo), .o_fault_flag_n_o(flag_o),
        .o_fault_flag_n_oe(flag_oe), .o_limit_type(ltype));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Delay until the chosen output reaches a level must fall in [lo, hi]
    task automatic wait_lvl(input bit use_flag, input logic val, input int lo, input int hi);
        int n;
        n = 0;
        while (((use_flag ? flag_oe : fet) !== val) && n <= hi)
        begin
            @(negedge clk);
            n++;
        end
        chk(32'(n >= lo && n <= hi), 32'h1);
        // Hand back on a rising edge so the next stimulus is driven there
        @(posedge clk);
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            fails++;
            wrap_up();
        end
    end
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial
    begin
        tick(6);
        rst_n <= 1'b1;
        tick(2);
        chk(ltype, 32'h2);
        chk(fet, 32'h0);
        chk(flag_oe, 32'h1);
        sel_lo <= 1'b0;
        sel_hi <= 1'b0;
        tick(20);
        chk(ltype, 32'h2);
        vout <= vin;
        tick(12);
        chk(ltype, 32'h0);
        vout <= 16'h0;
        mode <= 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            tick(1);
            {sel_hi, sel_lo} <= 2'(c);
            tick(10);
            chk(ltype, (c == 0) ? 32'h0 : (c == 1) ? 32'h1 : 32'h2);
        end
        for (int i = 0; i < 4; i++)
        begin
            {hv_n, en} <= 2'(i);
            tick(DEB + SLK + 6);
            chk(fet, 32'(i != 2));
        end
        vin <= 16'h1f40;
        wait_lvl(0, 1'b0, 0, SLK);
        tick(1);
        vin <= 16'h5dc0;
        wait_lvl(0, 1'b1, DEB, DEB + SLK);
        tick(1);
        load <= 16'h384;
        wait_lvl(1, 1'b0, BLK, BLK + SLK);
        chk({fet, cla}, 32'h3);
        load <= 16'h64;
        wait_lvl(1, 1'b1, 0, SLK);
        load <= 16'h384;
        tick(BLK / 2);
        load <= 16'h64;
        tick(4);
        load <= 16'h384;
        wait_lvl(1, 1'b0, BLK, BLK + SLK);
        load <= 16'h64;
        sel_hi <= 1'b0;
        wait_lvl(1, 1'b1, 0, SLK);
        chk(ltype, 32'h1);
        load <= 16'h384;
        wait_lvl(1, 1'b0, BLK, BLK + SLK);
        wait_lvl(0, 1'b0, 0, SLK);
        wait_lvl(0, 1'b1, RTY - 2, RTY + SLK);
        tick(4);
        chk(flag_oe, 32'h0);
        wait_lvl(0, 1'b0, BLK - 2, BLK + SLK);
        chk(flag_oe, 32'h0);
        load <= 16'h64;
        wait_lvl(0, 1'b1, RTY - 2, RTY + SLK);
        tick(3 * BLK);
        chk(fet, 32'h1);
        temp <= 8'ha0;
        wait_lvl(0, 1'b0, 0, 8);
        chk(flag_oe, 32'h0);
        temp <= 8'h82;
        tick(2 * RTY);
        chk(fet, 32'h0);
        temp <= 8'h64;
        wait_lvl(0, 1'b1, RTY - 2, RTY + 2 * SLK);
        sel_hi <= 1'b1;
        temp <= 8'ha0;
        wait_lvl(0, 1'b0, 0, 8);
        temp <= 8'h64;
        wait_lvl(0, 1'b1, 0, DEB + SLK);
        sel_hi <= 1'b0;
        sel_lo <= 1'b0;
        tick(8);
        temp <= 8'ha0;
        wait_lvl(0, 1'b0, 0, 8);
        temp <= 8'h19;
        tick(2 * RTY);
        chk(fet, 32'h0);
        en <= 1'b0;
        tick(8);
        en <= 1'b1;
        wait_lvl(0, 1'b1, 0, DEB + SLK);
        tick(1);
        load <= 16'h384;
        wait_lvl(1, 1'b0, BLK, BLK + SLK);
        wait_lvl(0, 1'b0, 0, SLK);
        load <= 16'h64;
        tick(2 * RTY);
        chk(fet, 32'h0);
        vin <= 16'h1f40;
        tick(8);
        vin <= 16'h5dc0;
        wait_lvl(0, 1'b1, DEB, DEB + 2 * SLK);
        sel_hi <= 1'b1;
        ov_sel <= 1'b0;
        vin <= 16'h84d0;
        wait_lvl(0, 1'b0, 0, SLK);
        chk(flag_oe, 32'h0);
        ov_sel <= 1'b1;
        wait_lvl(0, 1'b1, 0, DEB + 2 * SLK);
        vin <= 16'h4650;
        uv_sel <= 1'b0;
        wait_lvl(0, 1'b0, 0, SLK);
        vin <= 16'h5dc0;
        wait_lvl(0, 1'b1, 0, DEB + 2 * SLK);
        limit_set_pin_gnd <= 1'b1;
        wait_lvl(0, 1'b0, 0, SLK);
        chk(flag_oe, 32'h0);
        limit_set_pin_gnd <= 1'b0;
        wait_lvl(0, 1'b1, 0, DEB + 2 * SLK);
        rev_dis <= 1'b1;
        rev <= 1'b1;
        tick(SLK);
        chk({rbo, flag_oe, flag_o}, 32'h2);
        rev_dis <= 1'b0;
        wait_lvl(1, 1'b0, 0, SLK);
        chk(rbo, 32'h1);
        wrap_up();
    end
endmodule // tb_ocf_ctrl
`default_nettype wire
